// ---- eeprom_data_access_ctrl.sv ----
// byte access controller for the 128-byte non-volatile data memory
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - 128 bytes, 7-bit address, one byte each
// - control bits 3..0 as listed, upper zero
// - read starts on trigger with enable high
// - read trigger ignored while read enable low
// - read end clears trigger, data valid
// - data register holds until next operation
// - write trigger ignored while write enable low
// - write timed by asynchronous sub clock timer
// - write end clears write trigger
// - reset clears write enable
// - reset zeroes pointer high, hiding control
// - write end sets flag, even with enable low
// - vector request needs both enables, stack free
// - servicing interrupt clears flag
// - sleep input aborts pending operation
module eeprom_data_access_ctrl
    import nv_access_pkg::*;
#(
    parameter int WR_TICKS = WR_TICKS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sub_clk_i,
    input wire logic sleep_i,
    input wire logic stack_full_i,
    input wire logic int_ack_i,
    output logic int_req_o,
    output logic busy_o
);
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] nv_address_reg;
    logic [DATA_W-1:0] nv_data_reg;
    ctrl_t nv_control_reg;
    logic [7:0] pointer1_low;
    logic [7:0] pointer1_high;
    logic global_int_enable;
    logic nv_int_enable;
    logic nv_int_flag;
    state_t state;
    state_t next_state;
    logic [2:0] rd_cnt;
    logic wb_ack;
    logic [31:0] rd_word;
    logic wr_done;

    // bus decode; writes land on the edge that also sees ack
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack;
    wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack & wb_sel_i[0];
    wire [7:0] wdat = wb_dat_i[7:0];
    wire sel_addr = wb_adr_i == OFF_ADDR;
    wire sel_data = wb_adr_i == OFF_DATA;
    wire sel_iar = wb_adr_i == OFF_INDIRECT_ACCESS_REG1;
    wire sel_p1l = wb_adr_i == OFF_P1L;
    wire sel_p1h = wb_adr_i == OFF_P1H;
    wire sel_intc = wb_adr_i == OFF_INTC;
    wire idle = state == ST_IDLE;
    wire wr_busy = state == ST_WRITE;

    // control register is only visible through pointer 01H:40H
    wire ctrl_window = pointer1_high == CTRL_SECTOR && pointer1_low == CTRL_LOC;
    wire wr_ctrl = wb_wr & sel_iar & ctrl_window & ~wr_busy;

    // triggers need their enable already high; setting both in one
    // write therefore starts nothing
    wire start_wr = wr_ctrl & wdat[WR_BIT] & nv_control_reg.write_enable_bit & idle;
    wire start_rd = wr_ctrl & wdat[RD_BIT] & nv_control_reg.read_enable_bit & idle & ~start_wr;
    wire rd_done = state == ST_READ && rd_cnt == RD_LAST;
    wire abort = sleep_i & ~idle;
    wire rd_ok = rd_done & ~sleep_i;
    wire wr_ok = wr_done & wr_busy & ~sleep_i;
    wire [DATA_W-1:0] rd_byte = mem[nv_address_reg];

    wire flag_set = wr_ok;
    wire flag_sw_clr = wb_wr & sel_intc & ~wdat[IF_BIT];
    wire flag_clr = int_ack_i | flag_sw_clr;

    wire [7:0] ctrl_byte = {4'h0, nv_control_reg};
    wire [7:0] iar_byte = ctrl_window ? ctrl_byte : RST_BYTE;
    wire [7:0] intc_byte = {5'h00, nv_int_flag, nv_int_enable, global_int_enable};
    wire [7:0] rd_sel = sel_addr ? {1'b0, nv_address_reg} :
                        sel_data ? nv_data_reg :
                        sel_iar ? iar_byte :
                        sel_p1l ? pointer1_low :
                        sel_p1h ? pointer1_high :
                        sel_intc ? intc_byte : RST_BYTE;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start_wr) begin
                    next_state = ST_WRITE;
                end else if (start_rd) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (rd_done || sleep_i) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (wr_done || sleep_i) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            rd_cnt <= RST_CNT;
        end else begin
            state <= next_state;
            rd_cnt <= (state == ST_READ) ? rd_cnt + 3'h1 : RST_CNT;
        end
    end

    // write duration comes from the sub clock, not from clk_i
    nv_write_timer #(
        .TICKS(WR_TICKS)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sub_clk_i(sub_clk_i),
        .start_i(start_wr),
        .abort_i(abort),
        .done_o(wr_done)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack <= 1'b0;
            rd_word <= 32'h0000_0000;
        end else begin
            wb_ack <= wb_req;
            if (wb_req && !wb_we_i) begin
                rd_word <= {24'h00_0000, rd_sel};
            end
        end
    end

    // address and data are frozen while a write runs, guarding
    // against software that ignores the wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_address_reg <= RST_ADDR;
            nv_data_reg <= RST_BYTE;
            pointer1_low <= RST_BYTE;
            pointer1_high <= RST_BYTE;
        end else begin
            if (wb_wr && sel_addr && idle) begin
                nv_address_reg <= wdat[ADDR_W-1:0];
            end
            if (rd_ok) begin
                nv_data_reg <= rd_byte;
            end else if (wb_wr && sel_data && idle) begin
                nv_data_reg <= wdat;
            end
            if (wb_wr && sel_p1l) begin
                pointer1_low <= wdat;
            end
            if (wb_wr && sel_p1h) begin
                pointer1_high <= wdat;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_ok) begin
            mem[nv_address_reg] <= nv_data_reg;
        end
    end

    // software cannot clear a running trigger; only completion or a sleep abort does
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_control_reg <= CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                nv_control_reg.write_enable_bit <= wdat[WRITE_ENABLE_BIT_BIT];
                nv_control_reg.read_enable_bit <= wdat[READ_ENABLE_BIT_BIT];
            end
            if (start_wr) begin
                nv_control_reg.wr <= 1'b1;
            end else if (wr_done || abort) begin
                nv_control_reg.wr <= 1'b0;
            end
            if (start_rd) begin
                nv_control_reg.rd <= 1'b1;
            end else if (rd_done || abort) begin
                nv_control_reg.rd <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_int_enable <= 1'b0;
            nv_int_enable <= 1'b0;
            nv_int_flag <= 1'b0;
        end else begin
            if (wb_wr && sel_intc) begin
                global_int_enable <= wdat[GIE_BIT];
                nv_int_enable <= wdat[IE_BIT];
            end
            if (flag_set) begin
                nv_int_flag <= 1'b1;
            end else if (flag_clr) begin
                nv_int_flag <= 1'b0;
            end
        end
    end

    assign int_req_o = nv_int_flag & nv_int_enable & global_int_enable & ~stack_full_i;
    assign wb_ack_o = wb_ack;
    assign wb_dat_o = rd_word;
    assign busy_o = ~idle;

    rd_held_a: assert property (@(posedge clk_i) disable iff (rst_i || sleep_i)
        start_rd |=> nv_control_reg.rd [*4] ##1 !nv_control_reg.rd)
        else $error("read trigger not held for the read length");

    rd_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl && wdat[RD_BIT] && !nv_control_reg.read_enable_bit && !nv_control_reg.rd
        |=> !nv_control_reg.rd && state != ST_READ)
        else $error("read started without read enable");

    wr_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl && wdat[WR_BIT] && !nv_control_reg.write_enable_bit && !nv_control_reg.wr
        |=> !nv_control_reg.wr && state != ST_WRITE)
        else $error("write started without write enable");

    rd_data_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ok |=> nv_data_reg == $past(rd_byte) && !nv_control_reg.rd)
        else $error("read data not loaded at read end");

    data_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rd_ok && !(wb_wr && sel_data && idle) |=> $stable(nv_data_reg))
        else $error("data register changed without an operation");

    wr_timed_a: assert property (@(posedge clk_i) disable iff (rst_i || sleep_i)
        start_wr |=> nv_control_reg.wr [*3])
        else $error("write ended faster than the sub clock allows");

    wr_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok |=> !nv_control_reg.wr && nv_int_flag && idle
        && mem[$past(nv_address_reg)] == $past(nv_data_reg))
        else $error("write end did not store, clear trigger and flag");

    int_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        int_req_o |-> nv_int_flag && nv_int_enable && global_int_enable
        && !stack_full_i)
        else $error("interrupt request without its enables");

    flag_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        int_ack_i && !flag_set |=> !nv_int_flag)
        else $error("serviced interrupt left its flag set");

    reset_state_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> !nv_control_reg.write_enable_bit && pointer1_high == RST_BYTE
        && !ctrl_window)
        else $error("reset left writes or the control sector open");

    sleep_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
        abort |=> idle && !nv_control_reg.rd && !nv_control_reg.wr
        && !nv_int_flag == !$past(nv_int_flag))
        else $error("sleep did not abort the pending operation");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack |=> !wb_ack)
        else $error("bus acknowledge held for more than a cycle");

    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req |=> wb_ack && wb_dat_o[31:8] == 24'h00_0000)
        else $error("bus request not answered in the next cycle");

    ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack |-> $past(wb_req))
        else $error("bus acknowledge without a request");

    rd_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start_rd |=> nv_control_reg.rd && state == ST_READ && busy_o)
        else $error("read trigger with enable did not start a read");

    wr_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start_wr |=> nv_control_reg.wr && state == ST_WRITE && busy_o)
        else $error("write trigger with enable did not start a write");

    ctrl_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_wr && sel_iar && !ctrl_window
        |=> $stable(nv_control_reg.write_enable_bit) && $stable(nv_control_reg.read_enable_bit))
        else $error("control bits changed outside the control window");

    regs_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_busy |=> $stable(nv_address_reg) && $stable(nv_data_reg))
        else $error("address or data changed while a write ran");

    flag_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(nv_int_flag) |-> $past(wr_ok))
        else $error("interrupt flag rose without a write end");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        nv_int_flag && !flag_clr |=> nv_int_flag)
        else $error("interrupt flag dropped without a clear");

    // cycles spent in the running write; sub clock rises are at least
    // two cycles apart, so a write can never be shorter than its ticks
    logic [15:0] wr_len;
    always_ff @(posedge clk_i) begin
        if (rst_i || !wr_busy) begin
            wr_len <= 16'h0000;
        end else if (wr_len != 16'hFFFF) begin
            wr_len <= wr_len + 16'h0001;
        end
    end

    wr_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok |-> wr_len >= 16'(WR_TICKS))
        else $error("write shorter than its sub clock ticks");
endmodule : eeprom_data_access_ctrl
`default_nettype wire

// ---- nv_access_pkg.sv ----
// constants and types for the non-volatile data memory access block
`default_nettype none
package nv_access_pkg;
    localparam int DEPTH = 128;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_INDIRECT_ACCESS_REG1 = 8'h08;
    localparam logic [7:0] OFF_P1L = 8'h0C;
    localparam logic [7:0] OFF_P1H = 8'h10;
    localparam logic [7:0] OFF_INTC = 8'h14;

    localparam logic [7:0] CTRL_SECTOR = 8'h01;
    localparam logic [7:0] CTRL_LOC = 8'h40;

    localparam int WRITE_ENABLE_BIT_BIT = 3;
    localparam int WR_BIT = 2;
    localparam int READ_ENABLE_BIT_BIT = 1;
    localparam int RD_BIT = 0;
    localparam int GIE_BIT = 0;
    localparam int IE_BIT = 1;
    localparam int IF_BIT = 2;

    localparam int RD_CYCLES = 4;
    localparam logic [2:0] RD_LAST = 3'(RD_CYCLES - 1);
    localparam int WR_TICKS_DEF = 64;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic [2:0] RST_CNT = 3'h0;

    typedef struct packed {
        logic write_enable_bit;
        logic wr;
        logic read_enable_bit;
        logic rd;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = ctrl_t'(4'h0);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } state_t;
endpackage : nv_access_pkg
`default_nettype wire

// ---- nv_write_timer.sv ----
// write cycle timer counting edges of the low-speed subsidiary clock
`timescale 1ns/1ns
`default_nettype none
module nv_write_timer #(
    parameter int TICKS = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sub_clk_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic done_o
);
    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_ZERO = CW'(0);

    logic sync1;
    logic sync2;
    logic sync3;
    logic [CW-1:0] cnt;
    logic done;
    wire sub_rise = sync2 & ~sync3;
    wire last_tick = sub_rise && (cnt == CNT_ONE);

    // sub clock is foreign to clk_i; sync1 feeds only sync2
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= sub_clk_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            cnt <= CNT_ZERO;
            done <= 1'b0;
        end else if (start_i) begin
            cnt <= CW'(TICKS);
            done <= 1'b0;
        end else begin
            done <= last_tick;
            if (sub_rise && cnt != CNT_ZERO) begin
                cnt <= cnt - CNT_ONE;
            end
        end
    end

    assign done_o = done;
endmodule : nv_write_timer
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the non-volatile data memory access block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("BAD %s expected %h seen %h", nm, e, g); \
    end \
end
module testbench;
    import nv_access_pkg::*;
    // short write timer keeps the run brief
    localparam int TICKS = 3;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic sub_clk_i = 1'b0;
    logic sleep_i = 1'b0;
    logic stack_full_i = 1'b0;
    logic int_ack_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic int_req_o;
    logic busy_o;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] mem [DEPTH];
    logic [6:0] addrs [4];
    logic [7:0] q;
    logic [7:0] d;

    eeprom_data_access_ctrl #(.WR_TICKS(TICKS)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sub_clk_i(sub_clk_i), .sleep_i(sleep_i),
        .stack_full_i(stack_full_i), .int_ack_i(int_ack_i),
        .int_req_o(int_req_o), .busy_o(busy_o));

    always #10 clk_i = ~clk_i;
    // slow clock, half period above three system clocks, rises on system clock rises
    always #70 sub_clk_i = ~sub_clk_i;

    function automatic logic irq(logic f, logic ie, logic ge, logic sf);
        return f & ie & ge & ~sf;
    endfunction : irq

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        `CHECK("ack wait", 2, n)
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // polls a control bit until hardware clears it, bounded
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
            n++;
        end while (q[b] !== 1'b0 && n < 100);
    endtask : poll

    task automatic start_read(input logic [6:0] a);
        wb(1'b1, OFF_ADDR, {1'b0, a}, q);
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h02, q);
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h03, q);
    endtask : start_read

    task automatic start_write();
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h08, q);
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h0C, q);
    endtask : start_write

    initial begin
        void'($urandom(15));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        `CHECK("ctrl hidden", 8'h00, q)
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h08, q);
        wb(1'b1, OFF_P1L, CTRL_LOC, q);
        wb(1'b1, OFF_P1H, CTRL_SECTOR, q);
        wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        `CHECK("ctrl reset", 8'h00, q)
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h04, q);
        #1;
        `CHECK("no write busy", 1'b0, busy_o)
        @(posedge clk_i);
        wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        `CHECK("wr without write_enable_bit", 8'h00, q)
        wb(1'b1, 8'h18, 8'hFF, q);
        wb(1'b0, 8'h18, 8'h00, q);
        `CHECK("unmapped", 8'h00, q)
        // end addresses first, then random ones
        for (int i = 0; i < 4; i++) begin
            addrs[i] = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
            d = 8'($urandom);
            mem[addrs[i]] = d;
            wb(1'b1, OFF_INTC, 8'h00, q);
            wb(1'b1, OFF_ADDR, {1'b0, addrs[i]}, q);
            wb(1'b1, OFF_DATA, d, q);
            start_write();
            #1;
            `CHECK("write busy", 1'b1, busy_o)
            @(posedge clk_i);
            wb(1'b1, OFF_INTC, 8'h01, q);
            poll(WR_BIT);
            `CHECK("wr cleared", 1'b0, q[WR_BIT])
            wb(1'b0, OFF_INTC, 8'h00, q);
            `CHECK("flag set", 3'b101, q[2:0])
            `CHECK("masked", irq(1'b1, 1'b0, 1'b1, 1'b0), int_req_o)
        end
        // writing one to the flag leaves it alone
        wb(1'b1, OFF_INTC, 8'h07, q);
        #1;
        `CHECK("irq", irq(1'b1, 1'b1, 1'b1, 1'b0), int_req_o)
        @(posedge clk_i);
        stack_full_i <= 1'b1;
        @(posedge clk_i);
        #1;
        `CHECK("irq full", irq(1'b1, 1'b1, 1'b1, 1'b1), int_req_o)
        @(posedge clk_i);
        stack_full_i <= 1'b0;
        int_ack_i <= 1'b1;
        @(posedge clk_i);
        int_ack_i <= 1'b0;
        wb(1'b0, OFF_INTC, 8'h00, q);
        `CHECK("flag serviced", 3'b011, q[2:0])
        `CHECK("irq off", 1'b0, int_req_o)
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'hF2, q);
        wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        `CHECK("ctrl upper", 8'h02, q)
        for (int i = 3; i >= 0; i--) begin
            start_read(addrs[i]);
            #1;
            `CHECK("read busy", 1'b1, busy_o)
            repeat (RD_CYCLES - 2) @(posedge clk_i);
            #1;
            `CHECK("read held", 1'b1, busy_o)
            @(posedge clk_i);
            #1;
            `CHECK("read end", 1'b0, busy_o)
            @(posedge clk_i);
            poll(RD_BIT);
            `CHECK("rd cleared", 8'h02, q)
            wb(1'b0, OFF_DATA, 8'h00, q);
            `CHECK("read data", mem[addrs[i]], q)
        end
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        wb(1'b1, OFF_INDIRECT_ACCESS_REG1, 8'h01, q);
        #1;
        `CHECK("rd no read_enable_bit", 1'b0, busy_o)
        @(posedge clk_i);
        wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        `CHECK("rd ignored", 8'h00, q)
        wb(1'b0, OFF_DATA, 8'h00, q);
        `CHECK("data kept", mem[addrs[0]], q)
        // sleep in mid-write must leave the stored byte untouched
        wb(1'b1, OFF_DATA, ~mem[addrs[0]], q);
        start_write();
        sleep_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sleep_i <= 1'b0;
        #1;
        `CHECK("abort idle", 1'b0, busy_o)
        @(posedge clk_i);
        wb(1'b0, OFF_INDIRECT_ACCESS_REG1, 8'h00, q);
        `CHECK("abort wr", 1'b0, q[WR_BIT])
        wb(1'b0, OFF_INTC, 8'h00, q);
        `CHECK("abort flag", 1'b0, q[2])
        start_read(addrs[0]);
        poll(RD_BIT);
        wb(1'b0, OFF_DATA, 8'h00, q);
        `CHECK("abort data", mem[addrs[0]], q)
        close_out();
    end

    initial begin
        #400000;
        mismatches++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
